/* hdl/adcpr_buf2.sv */
// Two-entry result buffer between the converter core and the host readout.
// Assumes both sides run on core_clk and follow valid/ready.
`timescale 1ns/1ps
`include "adcpr_consts.svh"

module adcpr_buf2 (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 flush,
  input  wire logic                 in_valid,
  output      logic                 in_ready,
  input  wire adcpr_pkg::adcpr_code_t in_data,
  output      logic                 out_valid,
  input  wire logic                 out_ready,
  output      adcpr_pkg::adcpr_code_t out_data
);
  import adcpr_pkg::*;

  adcpr_code_t mem_q [2];
  adcpr_code_t mem_d [2];
  logic        wr_q, wr_d;
  logic        rd_q, rd_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        push, pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d  = 1'b0;
      rd_d  = 1'b0;
      cnt_d = 2'd0;
    end else begin
      if (push) begin
        mem_d[wr_q] = in_data;
        wr_d        = ~wr_q;
      end
      if (pop) begin
        rd_d = ~rd_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

/* hdl/adcpr_top.sv */
// Conversion sequencing and parallel result readout of the 14-bit converter.
// Assumes a converter core on core_clk that answers each hold_start with one code.
//
// Overview of operation
// - EOC flag goes low when a conversion result is ready.
// - Result bus stays high-impedance during acquisition and conversion.
// - Third strobe fall with read select high drives the result after a delay.
// - Strobe returning high releases the result bus.
// - After a read, wait for the next strobe fall before a new cycle.
// - Each result bit is a three-state driver with its own enable.
// - Wide variant drives 14 bits; byte variant drives eight bits.
// - Byte variant: low byte when byte select low, high byte when high.
// - Reset pin with strobe high puts the device into a known ready state.
// - After a reset pulse, the next strobe fall begins acquisition.
// - Result is straight unsigned binary, zero input gives all zeros.
// - First strobe fall with read select low wakes; with it high, ignored.
// - Second strobe fall ends acquisition, holds sample, starts conversion.
// - Conversion finishes within 4.7 us from hold to EOC falling.
// - Read select at second fall: low keeps reference on, high shuts down.
`timescale 1ns/1ps
`include "adcpr_consts.svh"

module adcpr_top #(
  parameter bit BYTE_WIDE = 1'b0
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire adcpr_pkg::adcpr_pins_t host_pins,
  output      logic                   eoc_n,
  output      adcpr_pkg::adcpr_bus_t  result_bus,
  output      logic                   hold_start,
  output      logic                   ref_on,
  input  wire logic                   sar_valid,
  output      logic                   sar_ready,
  input  wire adcpr_pkg::adcpr_code_t sar_data
);
  import adcpr_pkg::*;

  localparam int CONV_MAX = `ADCPR_CONV_MAX_CYC;

  // ----------------------------------------
  // Pin synchronisers and strobe edges
  // ----------------------------------------
  adcpr_pins_t pins_s1_q, pins_s2_q;
  logic        sel_n_s3_q;
  logic        sel_fall, sel_rise, rc, hbs, reset_lvl;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1_q  <= '{sel_n: 1'b1, rd_conv: 1'b0, high_byte_sel: 1'b0, reset_pin: 1'b0};
      pins_s2_q  <= '{sel_n: 1'b1, rd_conv: 1'b0, high_byte_sel: 1'b0, reset_pin: 1'b0};
      sel_n_s3_q <= 1'b1;
    end else begin
      pins_s1_q  <= host_pins;
      pins_s2_q  <= pins_s1_q;
      sel_n_s3_q <= pins_s2_q.sel_n;
    end
  end

  assign sel_fall  = sel_n_s3_q && !pins_s2_q.sel_n;
  assign sel_rise  = !sel_n_s3_q && pins_s2_q.sel_n;
  assign rc        = pins_s2_q.rd_conv;
  assign hbs       = pins_s2_q.high_byte_sel;
  assign reset_lvl = pins_s2_q.reset_pin;

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  logic        buf_valid, buf_pop, buf_flush;
  adcpr_code_t buf_data;

  adcpr_buf2 u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .flush     (buf_flush),
    .in_valid  (sar_valid),
    .in_ready  (sar_ready),
    .in_data   (sar_data),       // Code passed unchanged: straight binary
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // Lane placement of the held code on the bus
  function automatic adcpr_code_t lane_data(input adcpr_code_t code, input logic hi);
    adcpr_code_t v;
    v = code;
    if (BYTE_WIDE) begin
      v = hi ? (code >> `ADCPR_HI_LSB) : (code & `ADCPR_OE_BYTE);
    end
    return v;
  endfunction

  // ----------------------------------------
  // Conversion cycle sequencer
  // ----------------------------------------
  adcpr_state_t          state_q, state_d;
  logic                  eoc_n_q, eoc_n_d;
  logic                  ref_on_q, ref_on_d;
  logic                  mode_q, mode_d;
  logic                  hold_q, hold_d;
  adcpr_bus_t            bus_q, bus_d;
  logic [`ADCPR_CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    state_d   = state_q;
    eoc_n_d   = eoc_n_q;
    ref_on_d  = ref_on_q;
    mode_d    = mode_q;
    hold_d    = 1'b0;
    buf_pop   = 1'b0;
    buf_flush = 1'b0;
    cnt_d     = (state_q == ADCPR_CONV) ? cnt_q + 1'b1 : '0;
    if (reset_lvl) begin
      state_d   = ADCPR_IDLE;
      eoc_n_d   = 1'b1;
      buf_flush = 1'b1;
    end else begin
      case (state_q)
        ADCPR_IDLE: begin
          if (sel_fall && !rc) begin
            state_d  = ADCPR_ACQ;
            eoc_n_d  = 1'b1;
            ref_on_d = 1'b1;
          end
        end
        ADCPR_ACQ: begin
          if (sel_fall) begin
            state_d   = ADCPR_CONV;
            mode_d    = rc;
            hold_d    = 1'b1;
            // Drop a code left over from a conversion cut short by the reset pin
            buf_flush = 1'b1;
          end
        end
        ADCPR_CONV: begin
          if (buf_valid) begin
            state_d = ADCPR_DONE;
            eoc_n_d = 1'b0;
            if (mode_q) begin
              ref_on_d = 1'b0;
            end
          end
        end
        ADCPR_DONE: begin
          if (sel_fall && rc) begin
            state_d = ADCPR_READ;
          end
        end
        ADCPR_READ: begin
          if (sel_rise) begin
            state_d = ADCPR_IDLE;
            buf_pop = 1'b1;
          end
        end
        default: begin
          state_d = ADCPR_IDLE;
        end
      endcase
    end
    // Bus drives only while reading; dark in all other phases
    bus_d.oe   = '0;
    bus_d.data = '0;
    if (state_d == ADCPR_READ) begin
      bus_d.oe   = BYTE_WIDE ? `ADCPR_OE_BYTE : `ADCPR_OE_WIDE;
      bus_d.data = lane_data(buf_data, hbs);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ADCPR_IDLE;
      eoc_n_q  <= `ADCPR_EOC_N_RST;
      ref_on_q <= `ADCPR_REF_ON_RST;
      mode_q   <= `ADCPR_MODE_RST;
      hold_q   <= 1'b0;
      bus_q    <= '0;
      cnt_q    <= '0;
    end else begin
      state_q  <= state_d;
      eoc_n_q  <= eoc_n_d;
      ref_on_q <= ref_on_d;
      mode_q   <= mode_d;
      hold_q   <= hold_d;
      bus_q    <= bus_d;
      cnt_q    <= cnt_d;
    end
  end

  assign eoc_n      = eoc_n_q;
  assign result_bus = bus_q;
  assign hold_start = hold_q;
  assign ref_on     = ref_on_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_eoc_low_done;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_DONE || state_q == ADCPR_READ) |-> !eoc_n;
  endproperty
  a_eoc_low_done: assert property (p_eoc_low_done)
    else $error("EOC not low while result is ready");

  property p_bus_dark;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q inside {ADCPR_IDLE, ADCPR_ACQ, ADCPR_CONV}) |-> (result_bus.oe == '0);
  endproperty
  a_bus_dark: assert property (p_bus_dark)
    else $error("Result bus driven outside a read");

  property p_read_drive;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_DONE && sel_fall && rc && !reset_lvl)
        |=> (result_bus.oe != '0) && (result_bus.data == lane_data(buf_data, $past(hbs)));
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("Third strobe fall did not drive the result");

  property p_release;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_READ && sel_rise) |=> (result_bus.oe == '0) ##1 (result_bus.oe == '0);
  endproperty
  a_release: assert property (p_release)
    else $error("Bus not released after strobe rise");

  property p_wait_fall;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_IDLE && !sel_fall) |=> (state_q == ADCPR_IDLE);
  endproperty
  a_wait_fall: assert property (p_wait_fall)
    else $error("New cycle began without a strobe fall");

  property p_byte_lanes;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_READ)
        |-> (result_bus.oe == (BYTE_WIDE ? `ADCPR_OE_BYTE : `ADCPR_OE_WIDE));
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("Wrong set of result lanes enabled");

  property p_reset_idle;
    @(posedge core_clk) disable iff (!rst_n)
      reset_lvl |=> (state_q == ADCPR_IDLE) && eoc_n && !buf_valid;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("Reset pin did not restore a known state");

  property p_ignore_wake;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_IDLE && sel_fall && rc) |=> (state_q == ADCPR_IDLE) && !hold_start;
  endproperty
  a_ignore_wake: assert property (p_ignore_wake)
    else $error("Wake taken with read select high");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_ACQ && sel_fall && !reset_lvl)
        |=> hold_start && (state_q == ADCPR_CONV) && (mode_q == $past(rc)) ##1 !hold_start;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Second strobe fall did not start conversion");

  property p_conv_time;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_CONV) |-> (int'(cnt_q) < CONV_MAX);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("Conversion exceeded its longest time");

  property p_eoc_rise;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == ADCPR_IDLE && sel_fall && !rc && !reset_lvl) |=> eoc_n && ref_on;
  endproperty
  a_eoc_rise: assert property (p_eoc_rise)
    else $error("EOC not raised at start of a cycle");

endmodule

/* include/adcpr_consts.svh */
// Constants of the parallel result readout: widths, timing counts, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ADCPR_CONSTS_SVH
`define ADCPR_CONSTS_SVH

`define ADCPR_CODE_W         14
`define ADCPR_BYTE_W         8
`define ADCPR_HI_LSB         8
`define ADCPR_CLK_PERIOD_NS  4
`define ADCPR_T_CONV_MAX_NS  4700
`define ADCPR_CONV_MAX_CYC   (`ADCPR_T_CONV_MAX_NS / `ADCPR_CLK_PERIOD_NS)
`define ADCPR_CNT_W          11
`define ADCPR_EOC_N_RST      1'b1
`define ADCPR_REF_ON_RST     1'b0
`define ADCPR_MODE_RST       1'b0
`define ADCPR_OE_WIDE        14'h3fff
`define ADCPR_OE_BYTE        14'h00ff

`endif

/* include/adcpr_pkg.sv */
// Types shared by the readout top and its result buffer.
// Assumes adcpr_consts.svh is on the include path.
`include "adcpr_consts.svh"

package adcpr_pkg;

  typedef logic [`ADCPR_CODE_W-1:0] adcpr_code_t;

  // Host-side pins, all asynchronous to core_clk
  typedef struct packed {
    logic sel_n;
    logic rd_conv;
    logic high_byte_sel;
    logic reset_pin;
  } adcpr_pins_t;

  // Three-state result bus: value and per-bit output enable
  typedef struct packed {
    adcpr_code_t oe;
    adcpr_code_t data;
  } adcpr_bus_t;

  typedef enum logic [4:0] {
    ADCPR_IDLE = 5'b00001,
    ADCPR_ACQ  = 5'b00010,
    ADCPR_CONV = 5'b00100,
    ADCPR_DONE = 5'b01000,
    ADCPR_READ = 5'b10000
  } adcpr_state_t;

endpackage

/* tb/adcpr_sar_model.sv */
// Behavioural converter core that answers each hold_start with one code.
// Assumes the readout top on the same core_clk and its valid/ready handshake.
`timescale 1ns/1ps

module adcpr_sar_model (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   hold_start,
  input  wire logic                   sar_ready,
  input  wire logic [15:0]            delay,
  input  wire adcpr_pkg::adcpr_code_t code,
  output      logic                   sar_valid,
  output      adcpr_pkg::adcpr_code_t sar_data
);
  import adcpr_pkg::*;

  logic [15:0] cnt_q;
  logic        busy_q;

  // --------------------------------------------------------------------
  // Conversion timer and result handshake
  // --------------------------------------------------------------------
  // Code is held until taken; between results the data lines toggle so
  // that a stale word is never mistaken for a fresh one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 16'h0000;
      busy_q    <= 1'b0;
      sar_valid <= 1'b0;
      sar_data  <= 14'h0000;
    end else if (hold_start) begin
      cnt_q     <= delay;
      busy_q    <= 1'b1;
      sar_data  <= ~sar_data;
    end else if (sar_valid) begin
      if (sar_ready) begin
        sar_valid <= 1'b0;
        busy_q    <= 1'b0;
        sar_data  <= ~sar_data;
      end
    end else if (busy_q && cnt_q != 16'h0000) begin
      cnt_q    <= cnt_q - 16'h0001;
      sar_data <= ~sar_data;
    end else if (busy_q) begin
      sar_valid <= 1'b1;
      sar_data  <= code;
    end else begin
      sar_data <= ~sar_data;
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench: wide and byte variants side by side, one shared host.
// Assumes the readout top, its package and the converter model are compiled.
`timescale 1ns/1ps

module tb;
  import adcpr_pkg::*;

  logic                 core_clk = 1'b0;
  logic                 rst_n    = 1'b0;
  adcpr_pins_t          hp       = '{sel_n: 1'b1, rd_conv: 1'b0,
                                     high_byte_sel: 1'b0, reset_pin: 1'b0};
  logic [15:0]          dly      = 16'h0000;
  adcpr_code_t          code     = 14'h0000;
  logic                 eoc_w, eoc_b, hs_w, hs_b, ref_w, ref_b;
  logic                 sv_w, sv_b, sr_w, sr_b;
  adcpr_code_t          sd_w, sd_b;
  adcpr_bus_t           bus_w, bus_b;
  int                   err_count = 0;
  int                   checks_done = 0;
  int                   hsc = 0;
  int                   cyc = 0;

  always #2 core_clk = ~core_clk;

  adcpr_top #(.BYTE_WIDE(1'b0)) adcpr_top_i (.core_clk(core_clk), .rst_n(rst_n), .host_pins(hp),
    .eoc_n(eoc_w), .result_bus(bus_w), .hold_start(hs_w), .ref_on(ref_w),
    .sar_valid(sv_w), .sar_ready(sr_w), .sar_data(sd_w));
  adcpr_top #(.BYTE_WIDE(1'b1)) adcpr_top_byte_i (.core_clk(core_clk), .rst_n(rst_n),
    .host_pins(hp),
    .eoc_n(eoc_b), .result_bus(bus_b), .hold_start(hs_b), .ref_on(ref_b),
    .sar_valid(sv_b), .sar_ready(sr_b), .sar_data(sd_b));
  adcpr_sar_model adcpr_sar_model_i (.core_clk(core_clk), .rst_n(rst_n), .hold_start(hs_w),
    .sar_ready(sr_w), .delay(dly), .code(code), .sar_valid(sv_w), .sar_data(sd_w));
  adcpr_sar_model adcpr_sar_model_byte_i (.core_clk(core_clk), .rst_n(rst_n), .hold_start(hs_b),
    .sar_ready(sr_b), .delay(dly), .code(code), .sar_valid(sv_b), .sar_data(sd_b));

  // --------------------------------------------------------------------
  // Hold pulse counter and run limit
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (hs_w && hs_b) hsc++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Pin levels stay put long enough for the synchroniser and one answer
  task automatic pins(input logic s, input logic r, input logic h, input logic p);
    @(posedge core_clk);
    hp <= '{sel_n: s, rd_conv: r, high_byte_sel: h, reset_pin: p};
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_eoc();
    int n;
    n = 0;
    while ((eoc_w !== 1'b0 || eoc_b !== 1'b0) && n < 1300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("eoc_n both", 14'h0000, {12'h000, eoc_w, eoc_b});
    chk("conversion within limit", 14'h0001, 14'(n <= 1175));
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic conv(input adcpr_code_t c, input logic shut, input logic [15:0] d);
    int h0;
    @(posedge core_clk);
    code <= c;
    dly  <= d;
    h0 = hsc;
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk("eoc_n after wake", 14'h0003, {12'h000, eoc_w, eoc_b});
    chk("ref_on after wake", 14'h0003, {12'h000, ref_w, ref_b});
    chk("hold count at wake", 14'(h0), 14'(hsc));
    chk("oe in acquisition", 14'h0000, bus_w.oe | bus_b.oe);
    pins(1'b1, shut, 1'b0, 1'b0);
    pins(1'b0, shut, 1'b0, 1'b0);
    chk("hold count at hold", 14'(h0 + 1), 14'(hsc));
    if (d > 16'h0010) chk("oe in conversion", 14'h0000, bus_w.oe | bus_b.oe);
    wait_eoc();
    chk("ref_on after result", {12'h000, ~shut, ~shut}, {12'h000, ref_w, ref_b});
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    chk("oe before read", 14'h0000, bus_w.oe | bus_b.oe);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk("wide oe", 14'h3fff, bus_w.oe);
    chk("wide data", c, bus_w.data);
    chk("byte oe", 14'h00ff, bus_b.oe);
    chk("low byte", {6'h00, c[7:0]}, bus_b.data);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    chk("high byte", {8'h00, c[13:8]}, bus_b.data);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk("oe released", 14'h0000, bus_w.oe | bus_b.oe);
    chk("data released", 14'h0000, bus_w.data | bus_b.data);
  endtask

  task automatic ignored_wake();
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk("ref_on after refused fall", 14'h0000, {12'h000, ref_w, ref_b});
    pins(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // Reset pin mid-cycle with a result waiting, then a clean cycle
  task automatic pin_reset();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_eoc();
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk("eoc_n after reset pin", 14'h0003, {12'h000, eoc_w, eoc_b});
    chk("oe after reset pin", 14'h0000, bus_w.oe | bus_b.oe);
    chk("sar_ready after reset pin", 14'h0003, {12'h000, sr_w, sr_b});
    conv(14'h1234, 1'b1, 16'h0000);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    ignored_wake();
    conv(14'h0000, 1'b0, 16'h0000);
    conv(14'h3fff, 1'b1, 16'h0003);
    conv(14'h2a5c, 1'b0, 16'h03e8);
    pin_reset();
    test_done();
  end
endmodule
